// ==== rtl/avcbb_pkg.sv ====
// package for the decode buffer base state block
package avcbb_pkg;
   localparam int          AVCBB_DW_W          = 32;
   localparam int          AVCBB_CL_LSB        = 6;
   localparam int          AVCBB_PAGE_LSB      = 12;
   localparam int          AVCBB_NUM_RD        = 32;
   localparam int          AVCBB_NUM_POC       = 34;
   localparam int          AVCBB_ROW_MBS       = 128;
   localparam int          AVCBB_IDX_W         = 7;
   localparam int          AVCBB_MB_W          = 14;
   localparam int          AVCBB_FSI_W         = 5;
   localparam int          AVCBB_FSID_W        = 6;
   // header fields
   localparam logic [2:0]  AVCBB_CMD_TYPE      = 3'h3;
   localparam logic [1:0]  AVCBB_PIPE_CODE     = 2'h2;
   localparam logic [2:0]  AVCBB_OPCODE        = 3'h4;
   localparam logic [7:0]  AVCBB_SUB_OPCODE    = 8'h03;
   localparam logic [15:0] AVCBB_DW_LEN        = 16'h0048;
   // dword positions within the command, and the selector threshold 16
   localparam logic [6:0]  AVCBB_DW_HDR        = 7'h00;
   localparam logic [6:0]  AVCBB_DW_MVP        = 7'h02;
   localparam logic [6:0]  AVCBB_DW_MBINFO     = 7'h03;
   localparam logic [6:0]  AVCBB_DW_ITDATA     = 7'h04;
   localparam logic [6:0]  AVCBB_DW_DEBLK      = 7'h05;
   localparam logic [6:0]  AVCBB_DW_RD0        = 7'h06;
   localparam logic [6:0]  AVCBB_DW_WR_UP      = 7'h26;
   localparam logic [6:0]  AVCBB_DW_WR_LO      = 7'h27;
   localparam logic [6:0]  AVCBB_DW_POC0       = 7'h28;
   localparam logic [6:0]  AVCBB_DW_LAST       = 7'h49;
   localparam logic [4:0]  AVCBB_FSI_OWN       = 5'h10;

   typedef logic [25:0] avcbb_cl_type;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } avcbb_dw_type;

   typedef struct packed {
      logic [6:0]              mb_x;
      logic [AVCBB_MB_W-1:0]   mb_num;
      logic                    pair_mode;
      logic                    bottom;
      logic [4:0]              fs_sel;
      logic [4:0]              rd_ref;
      logic [AVCBB_FSID_W-1:0] fs_id;
      logic                    fs_bot;
      logic [5:0]              it_cl;
   } avcbb_req_type;

   typedef struct packed {
      logic [31:0] mvp_addr;
      logic [31:0] mbinfo_addr;
      logic [31:0] it_addr;
      logic [31:0] it_start;
      logic [31:0] deblk_addr;
      logic [31:0] col_rd_addr;
      logic [31:0] col_wr_addr;
      logic [31:0] poc;
   } avcbb_addr_type;
endpackage : avcbb_pkg

// ==== rtl/avcbb_core.sv ====
// decode buffer base state: command capture and address derivation
// Notes on behaviour
// RL1: row store base in bits 31:6
// RL2: row store indexed by macroblock column
// RL3: one line per pair mode, half otherwise
// RL4: info output one line per macroblock
// RL5: transform address is page base plus offset
// RL6: page base kept out of start address
// RL7: line offset gives emitted start address
// RL8: fixed slot per macroblock, tail undefined
// RL9: software matches base to indirect base
// RL10: deblock base aligned, two lines per macroblock
// RL11: 32 read bases, fixed 128-macroblock width
// RL12: selector 0..15 writes via read base 0
// RL13: selector 16, frame/top uses upper base
// RL14: selector 16, bottom uses lower base
// RL15: 34 signed order count entries
// RL16: entry 0 current, entry 1 bottom
// RL17: index is identifier 5:1 plus field bit
// RL18: state held until reset or rewrite
// RL19: header type, pipe, opcodes, length checked
module avcbb_core
   import avcbb_pkg::*;
#(
   parameter int SLOT_LINES = 32
) (
   // clock and reset
   input  wire logic           i_ref_clk,
   input  wire logic           i_rst,
   // command dword stream
   input  wire avcbb_dw_type   i_cmd,
   output logic                o_cmd_ready,
   output logic                o_hdr_error,
   output logic                o_state_valid,
   // address requests
   input  wire avcbb_req_type  i_req,
   output avcbb_addr_type      o_addr
);
   initial begin
      if (SLOT_LINES < 1 || SLOT_LINES > 64) $error("slot size out of range");
   end

   typedef enum logic [1:0] {ST_HDR, ST_BODY, ST_SKIP} avcbb_st_type;

   typedef struct packed {
      avcbb_st_type               st;
      logic [6:0]                 dw;
      logic                       hdr_err;
      logic                       valid;
      avcbb_cl_type               mvp;
      avcbb_cl_type               mbinfo;
      logic [19:0]                it_page;
      logic [5:0]                 it_off;
      avcbb_cl_type               deblk;
      avcbb_cl_type [AVCBB_NUM_RD-1:0] rd;
      avcbb_cl_type               wr_up;
      avcbb_cl_type               wr_lo;
      logic [AVCBB_NUM_POC-1:0][31:0] poc;
      avcbb_addr_type             addr;
   } avcbb_state_type;

   avcbb_state_type s_q;
   avcbb_state_type s_d;

   logic [31:0] hdr_want;
   assign hdr_want = {AVCBB_CMD_TYPE, AVCBB_PIPE_CODE, AVCBB_OPCODE, AVCBB_SUB_OPCODE, AVCBB_DW_LEN};
   assign o_cmd_ready = 1'b1;

   always_comb begin
      logic [6:0]  ridx;
      logic [5:0]  pidx;
      logic [31:0] line;
      logic [31:0] slot;
      ridx = 7'h00;
      pidx = 6'h00;
      line = 32'h0000_0000;
      slot = 32'h0000_0000;
      s_d = s_q;
      // command capture
      if (i_cmd.valid) begin
         case (s_q.st)
            ST_HDR: begin
               s_d.dw = 7'h01;
               if (i_cmd.data == hdr_want) begin // RL19
                  s_d.st = ST_BODY;
                  s_d.hdr_err = 1'b0;
               end else begin
                  s_d.hdr_err = 1'b1;
               end
            end
            ST_BODY: begin
               s_d.dw = s_q.dw + 7'h01;
               // low six bits of address dwords are reserved, dropped on capture; order counts keep all 32 bits
               if (s_q.dw == AVCBB_DW_MVP) s_d.mvp = i_cmd.data[31:AVCBB_CL_LSB]; // RL1
               if (s_q.dw == AVCBB_DW_MBINFO) s_d.mbinfo = i_cmd.data[31:AVCBB_CL_LSB];
               if (s_q.dw == AVCBB_DW_ITDATA) begin
                  s_d.it_page = i_cmd.data[31:AVCBB_PAGE_LSB]; // RL5
                  s_d.it_off = i_cmd.data[AVCBB_PAGE_LSB-1:AVCBB_CL_LSB];
               end
               if (s_q.dw == AVCBB_DW_DEBLK) s_d.deblk = i_cmd.data[31:AVCBB_CL_LSB]; // RL10
               if (s_q.dw >= AVCBB_DW_RD0 && s_q.dw < AVCBB_DW_WR_UP) begin
                  ridx = s_q.dw - AVCBB_DW_RD0;
                  s_d.rd[ridx[4:0]] = i_cmd.data[31:AVCBB_CL_LSB]; // RL11
               end
               if (s_q.dw == AVCBB_DW_WR_UP) s_d.wr_up = i_cmd.data[31:AVCBB_CL_LSB];
               if (s_q.dw == AVCBB_DW_WR_LO) s_d.wr_lo = i_cmd.data[31:AVCBB_CL_LSB];
               if (s_q.dw >= AVCBB_DW_POC0) begin
                  ridx = s_q.dw - AVCBB_DW_POC0;
                  s_d.poc[ridx[5:0]] = i_cmd.data; // RL15
               end
               if (s_q.dw == AVCBB_DW_LAST) begin
                  s_d.st = ST_HDR;
                  s_d.valid = 1'b1;
               end
            end
            default: s_d.st = ST_HDR;
         endcase
      end
      // address derivation; state only changes on a new command
      if (i_req.pair_mode) begin // RL3
         line = 32'(i_req.mb_x);
      end else begin
         line = 32'(i_req.mb_x) >> 1;
      end
      // half-line granularity in non-pair mode: odd column uses upper half
      s_d.addr.mvp_addr = {s_q.mvp, 6'h00} + (line << AVCBB_CL_LSB)
                          + (i_req.pair_mode ? 32'h0 : 32'(i_req.mb_x[0]) << (AVCBB_CL_LSB - 1)); // RL2
      s_d.addr.mbinfo_addr = {s_q.mbinfo, 6'h00} + (32'(i_req.mb_num) << AVCBB_CL_LSB); // RL4
      slot = 32'(i_req.mb_num) * 32'(SLOT_LINES);
      s_d.addr.it_addr = {s_q.it_page, s_q.it_off, 6'h00} + ((slot + 32'(i_req.it_cl)) << AVCBB_CL_LSB); // RL8
      s_d.addr.it_start = {20'h0_0000, s_q.it_off, 6'h00} + (slot << AVCBB_CL_LSB); // RL6 RL7
      s_d.addr.deblk_addr = {s_q.deblk, 6'h00} + (32'(i_req.mb_num) << (AVCBB_CL_LSB + 1)); // RL10
      // row store of fixed width regardless of picture
      s_d.addr.col_rd_addr = {s_q.rd[i_req.rd_ref], 6'h00}
                             + (32'(i_req.mb_x) << AVCBB_CL_LSB); // RL11
      if (i_req.fs_sel < AVCBB_FSI_OWN) begin
         s_d.addr.col_wr_addr = {s_q.rd[0], 6'h00}; // RL12
      end else if (i_req.bottom) begin
         s_d.addr.col_wr_addr = {s_q.wr_lo, 6'h00}; // RL14
      end else begin
         s_d.addr.col_wr_addr = {s_q.wr_up, 6'h00}; // RL13
      end
      s_d.addr.col_wr_addr = s_d.addr.col_wr_addr + (32'(i_req.mb_x) << AVCBB_CL_LSB);
      // entry 0/1 are current top/bottom; frame mode leaves odd entries unused
      pidx = {i_req.fs_id[5:1], i_req.fs_bot}; // RL16 RL17
      if (pidx < 6'(AVCBB_NUM_POC)) begin
         s_d.addr.poc = s_q.poc[pidx];
      end else begin
         s_d.addr.poc = 32'h0000_0000;
      end
   end

   // state is held across slices until reset or a new command
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0; // RL18
      end else begin
         s_q <= s_d;
      end
   end

   assign o_hdr_error   = s_q.hdr_err;
   assign o_state_valid = s_q.valid;
   assign o_addr        = s_q.addr;
endmodule : avcbb_core

// ==== dv/avcbb_core_props.sv ====
// assertions on the buffer base state ports
module avcbb_core_props
   import avcbb_pkg::*;
(
   // clock and reset
   input wire logic           i_ref_clk,
   input wire logic           i_rst,
   // watched ports
   input wire avcbb_dw_type   i_cmd,
   input wire logic           o_cmd_ready,
   input wire logic           o_hdr_error,
   input wire logic           o_state_valid,
   input wire avcbb_req_type  i_req,
   input wire avcbb_addr_type o_addr
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   AST_ERR_CAUSE: assert property ($rose(o_hdr_error) |-> $past(i_cmd.valid) || $past(i_cmd.valid, 2))
      else $error("error rose without a dword");
   AST_VALID_CAUSE: assert property ($rose(o_state_valid) |-> $past(i_cmd.valid) || $past(i_cmd.valid, 2))
      else $error("state valid rose without a dword");
   AST_PAGE_OUT: assert property (((o_addr.it_addr - o_addr.it_start) & 32'hFFF) == {20'h0_0000, $past(i_req.it_cl), 6'h00})
      else $error("start address carries page part");
   AST_LINE: assert property (((o_addr.mbinfo_addr | o_addr.deblk_addr | o_addr.col_rd_addr) & 32'h3F) == 32'h0)
      else $error("address not line aligned");
   AST_HALF: assert property (o_addr.mvp_addr[4:0] == 5'h0)
      else $error("row store address not half-line aligned");
   AST_OWN_WR: assert property ($past(i_req.fs_sel) < 5'h10 && $past(i_req.rd_ref) == 5'h0 |->
      o_addr.col_wr_addr == o_addr.col_rd_addr) else $error("write base not read base 0");
   AST_POC_HI: assert property ({$past(i_req.fs_id[5:1]), $past(i_req.fs_bot)} > 6'h21 |-> o_addr.poc == 32'h0)
      else $error("order count beyond list not zero");
   AST_HOLD: assert property (!$past(i_rst) && !i_cmd.valid && !$past(i_cmd.valid) && $stable(i_req)
      |=> $stable(o_addr)) else $error("addresses moved without cause");
endmodule : avcbb_core_props

// ==== dv/avcbb_streamer.sv ====
// command streamer model feeding dwords
module avcbb_streamer
   import avcbb_pkg::*;
(
   input  wire logic   i_ref_clk,
   output avcbb_dw_type o_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] words [0:73];
   initial o_cmd = '0;
   // gap after every fifth dword; idle data inverted so nothing stale looks valid
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_ref_clk);
         o_cmd <= {1'b1, words[i]};
         if (i % 5 == 4) begin
            @(posedge i_ref_clk);
            o_cmd <= {1'b0, ~words[i]};
         end
      end
      @(posedge i_ref_clk);
      o_cmd <= {1'b0, ~o_cmd.data};
   endtask : send
endmodule : avcbb_streamer

// ==== dv/avcbb_core_bench.sv ====
// self-checking bench for the buffer base state block
module avcbb_core_bench;
   import avcbb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk, i_rst, o_cmd_ready, o_hdr_error, o_state_valid;
   logic look = 1'b0;
   avcbb_dw_type   i_cmd;
   avcbb_req_type  i_req, q;
   avcbb_addr_type o_addr;
   logic [31:0] rs = 32'h5DB9;
   logic [31:0] w [0:73];
   logic [31:0] note_q [$];
   logic [63:0] r;
   int fails = 0;
   int samples_checked = 0;
   avcbb_core u_avcbb_core (.i_ref_clk, .i_rst, .i_cmd, .o_cmd_ready, .o_hdr_error, .o_state_valid, .i_req, .o_addr);
   avcbb_streamer u_avcbb_streamer (.i_ref_clk, .o_cmd(i_cmd));
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic send_cmd(input logic [31:0] hdr, input int n, input bit inv);
      foreach (w[i]) u_avcbb_streamer.words[i] = inv ? ~w[i] : w[i];
      u_avcbb_streamer.words[0] = hdr;
      u_avcbb_streamer.send(n);
      repeat (3) @(negedge i_ref_clk);
   endtask : send_cmd
   always @(negedge i_ref_clk) begin
      if (look) begin
         check("mvp", o_addr.mvp_addr, note_q.pop_front());
         check("mbinfo", o_addr.mbinfo_addr, note_q.pop_front());
         check("it_page", o_addr.it_addr - o_addr.it_start, note_q.pop_front());
         check("it_start", o_addr.it_start, note_q.pop_front());
         check("deblk", o_addr.deblk_addr, note_q.pop_front());
         check("col_rd", o_addr.col_rd_addr, note_q.pop_front());
         check("col_wr", o_addr.col_wr_addr, note_q.pop_front());
         check("poc", o_addr.poc, note_q.pop_front());
      end
   end
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      i_rst = 1'b1;
      i_req = '0;
      w[0] = {AVCBB_CMD_TYPE, AVCBB_PIPE_CODE, AVCBB_OPCODE, AVCBB_SUB_OPCODE, AVCBB_DW_LEN};
      for (int i = 1; i < 74; i++) begin
         w[i] = rnd() & (i < 40 ? 32'hFFFFFFC0 : 32'hFFFFFFFF);
      end
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(negedge i_ref_clk);
      check("state_valid", o_state_valid, 0);
      send_cmd(~w[0], 1, 0);
      check("hdr_error", o_hdr_error, 1);
      send_cmd(w[0], 74, 0);
      check("state_valid", o_state_valid, 1);
      check("hdr_error", o_hdr_error, 0);
      check("cmd_ready", o_cmd_ready, 1);
      send_cmd(~w[0], 6, 1);
      check("hdr_error", o_hdr_error, 1);
      $display("command capture done");
      for (int k = 0; k < 40; k++) begin
         r = {rnd(), rnd()};
         q = r[45:0];
         q.fs_sel = r[50] ? AVCBB_FSI_OWN : {1'b0, r[49:46]};
         if (k % 2 == 1) begin
            q.rd_ref = 5'h0;
         end
         @(posedge i_ref_clk);
         i_req <= q;
         note_q.push_back(w[2] + (q.pair_mode ? q.mb_x * 64 : q.mb_x * 32));
         note_q.push_back(w[3] + q.mb_num * 64);
         note_q.push_back({w[4][31:12], 12'h0} + 32'(q.it_cl) * 64);
         // slot of 32 lines per macroblock, page part kept out
         note_q.push_back({20'h0_0000, w[4][11:6], 6'h00} + 32'(q.mb_num) * 32 * 64);
         note_q.push_back(w[5] + q.mb_num * 128);
         note_q.push_back(w[6 + q.rd_ref] + q.mb_x * 64);
         note_q.push_back((q.fs_sel < AVCBB_FSI_OWN ? w[6] : q.bottom ? w[39] : w[38]) + q.mb_x * 64);
         note_q.push_back({q.fs_id[5:1], q.fs_bot} < 34 ? w[40 + {q.fs_id[5:1], q.fs_bot}] : 32'h0);
         @(posedge i_ref_clk);
         look <= 1'b1;
         @(posedge i_ref_clk);
         look <= 1'b0;
      end
      $display("address checks done");
      tally_and_finish();
   end
endmodule : avcbb_core_bench
bind avcbb_core avcbb_core_props u_avcbb_core_props (.i_ref_clk, .i_rst, .i_cmd, .o_cmd_ready, .o_hdr_error,
   .o_state_valid, .i_req, .o_addr);
